// ### supply_limit_pkg.sv
/*
  Package for the sensor-supply limit timing block: register offsets,
  configuration layout, timing constants and channel states.
  Assumes a single 25 MHz system clock.
*/
package supply_limit_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SUPPLY_A_CONFIG_ADDR = 8'h18;
  localparam logic [7:0] SUPPLY_B_CONFIG_ADDR = 8'h19;
  localparam logic [7:0] SUPPLY_CONFIG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Configuration byte, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] retry_select;
    logic dynamic_blanking;
    logic [1:0] blanking_select;
    logic double_limit;
    logic limit_disable;
    logic supply_on;
  } supply_config_t;

  // Comparator levels from the analog front end of one channel
  typedef struct packed {
    logic over_limit;
    logic below_pgood;
    logic below_9v;
    logic above_17v;
    logic above_18v;
  } supply_sense_t;

  // Drive towards the external supply switch of one channel
  typedef struct packed {
    logic gate_drive;
    logic sense_enable;
    logic double_limit;
  } supply_drive_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 125;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int FILTER_US = 200;
  localparam int FILTER_CYCLES = (CLK_HZ / 1_000_000) * FILTER_US;

  // Blanking times in microseconds and in ticks
  localparam int BLANK_0_US = 5_500;
  localparam int BLANK_1_US = 16_500;
  localparam int BLANK_2_US = 55_000;
  localparam int BLANK_3_US = 165_000;
  localparam logic [16:0] BLANK_0_TICKS = 17'(BLANK_0_US / TICK_US);
  localparam logic [16:0] BLANK_1_TICKS = 17'(BLANK_1_US / TICK_US);
  localparam logic [16:0] BLANK_2_TICKS = 17'(BLANK_2_US / TICK_US);
  localparam logic [16:0] BLANK_3_TICKS = 17'(BLANK_3_US / TICK_US);

  // Autoretry periods in milliseconds and in ticks
  localparam int RETRY_1_MS = 400;
  localparam int RETRY_2_MS = 4_000;
  localparam int RETRY_3_MS = 12_000;
  localparam logic [16:0] RETRY_1_TICKS = 17'(RETRY_1_MS * 1000 / TICK_US);
  localparam logic [16:0] RETRY_2_TICKS = 17'(RETRY_2_MS * 1000 / TICK_US);
  localparam logic [16:0] RETRY_3_TICKS = 17'(RETRY_3_MS * 1000 / TICK_US);
  localparam logic [1:0] RETRY_LATCH_OFF = 2'h0;

  localparam logic [16:0] COUNT_RESET = 17'h00000;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ON = 3'b010,
    ST_FAULT = 3'b100
  } supply_state_t;

endpackage

// ### sensor_supply_limit_timing.sv
/*
  Two-channel sensor-supply switch control: configuration registers,
  enable filter, current-limit blanking with dynamic shortening,
  doubled limit, limit disable and autoretry or latch-off.
  Assumes register writes come from the on-chip serial interface on
  the same clock, and comparator levels arrive asynchronously.
*/
// Overview of operation
// [R1] The blanking field picks 5.5 ms, 16.5 ms, 55 ms or 165 ms for codes 00 to 11.
// [R2] Dynamic blanking shortens the blanking time only when enabled and supply is below power-good.
// [R3] With dynamic blanking active and supply from 9 V to 17 V the blanking time is halved.
// [R4] With dynamic blanking active and supply below 9 V the blanking time is quartered.
// [R5] The double-limit bit doubles the current limit only while supply is above 18 V.
// [R6] The limit-disable bit turns off the sense amplifier and all current limiting.
// [R7] A filtered supply enable of one turns the channel's gate driver on.
// [R8] While the enable is zero the retry, latch-off and blanking timers are held in reset.
// [R9] Enable changes lasting under 200 us are ignored before reaching driver and timers.
// [R10] The retry field picks latch-off, 400 ms, 4 s or 12 s for codes 00 to 11.
// [R11] A host managing retry timing itself selects latch-off so the supply never restarts alone.
// [R12] The host keeps the enable at zero long enough after a fault for the switch to cool.
// [R13] Channel A uses the same retry encoding at bits 7:6 as channel B.
// [R14] A limit held past the blanking time turns the driver off, then retries unless latched off.
`timescale 1ns/100ps
`default_nettype none

module sensor_supply_limit_timing
  import supply_limit_pkg::*;
#(
  parameter int TICK_LEN = supply_limit_pkg::TICK_CYCLES,
  parameter int FILTER_LEN = supply_limit_pkg::FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register access
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  output logic [7:0] reg_rdata_out,
  // Comparators, index 0 is channel A, index 1 is channel B
  input wire supply_limit_pkg::supply_sense_t [1:0] sense_in,
  // Drive to the external supply switches
  output supply_limit_pkg::supply_drive_t [1:0] drive_out
);
  import supply_limit_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] blank_ticks(input supply_config_t cfg,
                                              input supply_sense_t sns);
    logic [16:0] base;
    base = BLANK_0_TICKS;
    case (cfg.blanking_select) // R1
      2'h0: base = BLANK_0_TICKS;
      2'h1: base = BLANK_1_TICKS;
      2'h2: base = BLANK_2_TICKS;
      default: base = BLANK_3_TICKS;
    endcase
    // Above 17 V but still below power-good keeps the full time
    if (cfg.dynamic_blanking && sns.below_pgood) begin // R2
      if (sns.below_9v) begin
        base = base >> 2; // R4
      end else if (!sns.above_17v) begin
        base = base >> 1; // R3
      end
    end
    return base;
  endfunction

  function automatic logic [16:0] retry_ticks(input logic [1:0] sel);
    logic [16:0] t;
    t = COUNT_RESET;
    case (sel) // R10 R13
      2'h1: t = RETRY_1_TICKS;
      2'h2: t = RETRY_2_TICKS;
      2'h3: t = RETRY_3_TICKS;
      default: t = COUNT_RESET;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  supply_config_t [1:0] config_reg;
  wire logic write_a = reg_write_in && (reg_addr_in == SUPPLY_A_CONFIG_ADDR);
  wire logic write_b = reg_write_in && (reg_addr_in == SUPPLY_B_CONFIG_ADDR);
  wire logic [7:0] next_rdata = (reg_addr_in == SUPPLY_A_CONFIG_ADDR) ? config_reg[0] :
                                (reg_addr_in == SUPPLY_B_CONFIG_ADDR) ? config_reg[1] :
                                8'h00;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      config_reg <= {SUPPLY_CONFIG_RESET, SUPPLY_CONFIG_RESET};
      reg_rdata_out <= 8'h00;
    end else begin
      if (write_a) begin
        config_reg[0] <= reg_wdata_in;
      end
      if (write_b) begin
        config_reg[1] <= reg_wdata_in;
      end
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Comparator synchronisers and shared time base
  // ----------------------------------------------------------------
  supply_sense_t [1:0] sense_meta;
  supply_sense_t [1:0] sense_sync;
  logic [15:0] tick_count;
  wire logic tick = (tick_count == 16'(TICK_LEN - 1));

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sense_meta <= '0;
      sense_sync <= '0;
      tick_count <= 16'h0000;
    end else begin
      sense_meta <= sense_in;
      sense_sync <= sense_meta;
      tick_count <= tick ? 16'h0000 : tick_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel control
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    supply_config_t cfg;
    supply_sense_t sns;
    logic enable_filtered;
    logic [15:0] filter_count;
    supply_state_t state;
    supply_state_t next_state;
    logic [16:0] count;
    logic [16:0] next_count;

    assign cfg = config_reg[ch];
    assign sns = sense_sync[ch];

    // Enable must hold its new value for the whole filter time
    wire logic enable_differs = (cfg.supply_on != enable_filtered);
    wire logic filter_done = (filter_count == 16'(FILTER_LEN - 1));
    wire logic limiting = sns.over_limit && !cfg.limit_disable; // R6
    wire logic blank_expired = (count >= blank_ticks(cfg, sns));
    wire logic retry_expired = (count >= retry_ticks(cfg.retry_select));
    wire logic latch_off = (cfg.retry_select == RETRY_LATCH_OFF);

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        enable_filtered <= 1'b0;
        filter_count <= 16'h0000;
      end else if (!enable_differs) begin
        filter_count <= 16'h0000; // R9
      end else if (filter_done) begin
        enable_filtered <= cfg.supply_on; // R9
        filter_count <= 16'h0000;
      end else begin
        filter_count <= filter_count + 16'h0001;
      end
    end

    always_comb begin
      next_state = state;
      next_count = count;
      case (state)
        ST_OFF: begin
          next_count = COUNT_RESET;
          if (enable_filtered) begin
            next_state = ST_ON; // R7
          end
        end
        ST_ON: begin
          if (!limiting) begin
            next_count = COUNT_RESET;
          end else if (blank_expired) begin
            next_state = ST_FAULT; // R14
            next_count = COUNT_RESET;
          end else if (tick) begin
            next_count = count + 17'h00001;
          end
        end
        ST_FAULT: begin
          // Latch-off waits here until software drops the enable
          if (!latch_off && retry_expired) begin
            next_state = ST_ON; // R14
            next_count = COUNT_RESET;
          end else if (!latch_off && tick) begin
            next_count = count + 17'h00001;
          end
        end
        default: begin
          next_state = ST_OFF;
          next_count = COUNT_RESET;
        end
      endcase
      if (!enable_filtered) begin
        next_state = ST_OFF; // R8
        next_count = COUNT_RESET; // R8
      end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        state <= ST_OFF;
        count <= COUNT_RESET;
        drive_out[ch] <= '0;
      end else begin
        state <= next_state;
        count <= next_count;
        drive_out[ch].gate_drive <= (next_state == ST_ON); // R7
        drive_out[ch].sense_enable <= enable_filtered && !cfg.limit_disable; // R6
        drive_out[ch].double_limit <= cfg.double_limit && sns.above_18v; // R5
      end
    end
  end

endmodule

`default_nettype wire

// ### supply_limit_properties.sv
/* Checker for the supply limit block, watching channel A.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module supply_limit_properties
  import supply_limit_pkg::*;
#(parameter int TICK_LEN = 4, parameter int FILTER_LEN = 8) (
  // Clock, reset and register access
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_rdata_out,
  // Switch side
  input wire supply_limit_pkg::supply_sense_t [1:0] sense_in,
  input wire supply_limit_pkg::supply_drive_t [1:0] drive_out
);
  supply_config_t cfg_a;
  int en_cnt;
  int lim_cnt;
  wire logic wr_a = reg_write_in && reg_addr_in == SUPPLY_A_CONFIG_ADDR;
  wire logic next_on = wr_a ? reg_wdata_in[0] : cfg_a.supply_on;
  // Counters saturate so long waits never wrap into a false match
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_a <= supply_config_t'(SUPPLY_CONFIG_RESET);
      en_cnt <= 0;
      lim_cnt <= 0;
    end else begin
      if (wr_a) cfg_a <= supply_config_t'(reg_wdata_in);
      en_cnt <= (next_on != cfg_a.supply_on) ? 0 : (en_cnt < 99999 ? en_cnt + 1 : en_cnt);
      lim_cnt <= sense_in[0].over_limit ? (lim_cnt < 99999 ? lim_cnt + 1 : lim_cnt) : 0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_READBACK: assert property (wr_a ##1 (reg_addr_in == SUPPLY_A_CONFIG_ADDR && !reg_write_in)
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("config readback wrong");
  AST_FILTER: assert property ($rose(drive_out[0].gate_drive) |-> en_cnt >= FILTER_LEN)
    else $error("gate rose on a short enable pulse");
  AST_ON: assert property (cfg_a.supply_on && en_cnt == FILTER_LEN + 5
    |-> drive_out[0].gate_drive) else $error("gate not on after enable");
  AST_OFF: assert property (!cfg_a.supply_on && en_cnt >= FILTER_LEN + 5
    |-> !drive_out[0].gate_drive && !drive_out[0].sense_enable) else $error("output on while off");
  AST_SENSE_OFF: assert property (cfg_a.limit_disable [*2] |-> !drive_out[0].sense_enable)
    else $error("sense amp on while limit disabled");
  AST_BLANK_MIN: assert property ($fell(drive_out[0].gate_drive) && cfg_a.supply_on
    |-> lim_cnt >= 10 * TICK_LEN) else $error("fault before shortest blanking");
  AST_BLANK_MAX: assert property (cfg_a.supply_on && !cfg_a.limit_disable
    && lim_cnt == (BLANK_3_TICKS + 1) * TICK_LEN + 8 |-> !drive_out[0].gate_drive)
    else $error("no fault after longest blanking");
  AST_LATCH: assert property (cfg_a.retry_select == RETRY_LATCH_OFF && en_cnt > FILTER_LEN + 5
    |-> !$rose(drive_out[0].gate_drive)) else $error("restart while latched off");
  AST_DOUBLE_ON: assert property ((cfg_a.double_limit && sense_in[0].above_18v) [*5]
    |-> drive_out[0].double_limit) else $error("double limit missing");
  AST_DOUBLE_OFF: assert property (!(cfg_a.double_limit && sense_in[0].above_18v) [*5]
    |-> !drive_out[0].double_limit) else $error("double limit unexpected");
  cover property ($fell(drive_out[0].gate_drive));
  cover property ($rose(drive_out[1].gate_drive));
  cover property (drive_out[0].double_limit);
endmodule
bind sensor_supply_limit_timing supply_limit_properties #(.TICK_LEN(TICK_LEN),
  .FILTER_LEN(FILTER_LEN)) chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_rdata_out(reg_rdata_out), .sense_in(sense_in), .drive_out(drive_out));
`default_nettype wire

// ### supply_switch_model.sv
/* Model of the external supply switches and their comparators.
   Assumes one supply voltage for both channels, set by the bench. */
`timescale 1ns/100ps
`default_nettype none
module supply_switch_model
  import supply_limit_pkg::*;
#(parameter int PGOOD_V = 20) (
  // Bench controls
  input wire logic [1:0] short_in,
  input wire logic [5:0] volts_in,
  // Block side
  input wire supply_limit_pkg::supply_drive_t [1:0] drive_in,
  output supply_limit_pkg::supply_sense_t [1:0] sense_out
);
  // A short draws current whenever the switch conducts; the comparator keeps
  // reporting it even with the amp off, so the block itself must ignore it
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign sense_out[i] = supply_sense_t'({drive_in[i].gate_drive & short_in[i],
      volts_in < 6'(PGOOD_V), volts_in < 6'h09, volts_in > 6'h11, volts_in > 6'h12});
  end
endmodule
`default_nettype wire

// ### sensor_supply_limit_timing_test.sv
/* Self-checking bench for the supply limit block.
   Assumes short tick and filter lengths to keep the run brief. */
`timescale 1ns/100ps
`default_nettype none
module sensor_supply_limit_timing_test;
  import supply_limit_pkg::*;
  localparam int T = 4;
  localparam int FL = 8;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [1:0] short = 2'h0;
  logic [5:0] volts = 6'h18;
  supply_sense_t [1:0] sense_in;
  supply_drive_t [1:0] drive_out;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  logic [7:0] cfg_t [10] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h28, 8'h28, 8'h28, 8'h28, 8'h28, 8'h08};
  logic [5:0] volt_t [10] = '{6'h18, 6'h18, 6'h18, 6'h18, 6'h0c, 6'h05, 6'h13, 6'h11, 6'h09, 6'h05};
  int exp_t [10] = '{BLANK_0_TICKS, BLANK_1_TICKS, BLANK_2_TICKS, BLANK_3_TICKS, BLANK_1_TICKS / 2,
    BLANK_1_TICKS / 4, BLANK_1_TICKS, BLANK_1_TICKS / 2, BLANK_1_TICKS / 2, BLANK_1_TICKS};
  always #20 clk_in = ~clk_in;
  sensor_supply_limit_timing #(.TICK_LEN(T), .FILTER_LEN(FL)) uut (.clk_in(clk_in),
    .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_rdata_out(reg_rdata_out), .sense_in(sense_in),
    .drive_out(drive_out));
  supply_switch_model far (.short_in(short), .volts_in(volts), .drive_in(drive_out),
    .sense_out(sense_in));
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR %0t took %0d cycles, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    repeat (2) @(posedge clk_in);
    #1 chk(reg_rdata_out, e);
  endtask
  task automatic set_volts(input logic [5:0] v);
    @(posedge clk_in);
    volts <= v;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_gate(input int ch, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (drive_out[ch].gate_drive !== lvl) begin
      @(posedge clk_in);
      #1 cnt++;
      if (cnt > lim) begin
        n_fail++;
        $display("ERROR %0t wait for gate timed out", $time);
        summarize();
      end
    end
  endtask
  task automatic fault(input int ch, input logic [7:0] cfg, output int cnt);
    wr(SUPPLY_A_CONFIG_ADDR + 8'(ch), cfg | 8'h01);
    wait_gate(ch, 1'b1, FL + 10, cnt);
    chk({7'h00, drive_out[ch].sense_enable}, 8'h01);
    @(posedge clk_in);
    short[ch] <= 1'b1;
    wait_gate(ch, 1'b0, 6000, cnt);
  endtask
  // Disable long enough for the switch to cool before the next enable
  task automatic off(input int ch);
    @(posedge clk_in);
    short[ch] <= 1'b0;
    wr(SUPPLY_A_CONFIG_ADDR + 8'(ch), 8'h00);
    repeat (FL + 10) @(posedge clk_in);
    #1 chk({7'h00, drive_out[ch].gate_drive}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(SUPPLY_A_CONFIG_ADDR, SUPPLY_CONFIG_RESET);
    rd(SUPPLY_B_CONFIG_ADDR, SUPPLY_CONFIG_RESET);
    wr(SUPPLY_A_CONFIG_ADDR, 8'hc6);
    wr(SUPPLY_B_CONFIG_ADDR, 8'h7a);
    wr(8'h1a, 8'hff);
    rd(SUPPLY_A_CONFIG_ADDR, 8'hc6);
    rd(SUPPLY_B_CONFIG_ADDR, 8'h7a);
    rd(8'h1a, 8'h00);
    wr(SUPPLY_B_CONFIG_ADDR, 8'h00);
    wr(SUPPLY_A_CONFIG_ADDR, 8'h01);
    wr(SUPPLY_A_CONFIG_ADDR, 8'h00);
    repeat (FL + 10) @(posedge clk_in);
    #1 chk({7'h00, drive_out[0].gate_drive}, 8'h00);
    wr(SUPPLY_A_CONFIG_ADDR, 8'h04);
    set_volts(6'h18);
    chk({7'h00, drive_out[0].double_limit}, 8'h01);
    set_volts(6'h0c);
    chk({7'h00, drive_out[0].double_limit}, 8'h00);
    wr(SUPPLY_A_CONFIG_ADDR, 8'h00);
    set_volts(6'h18);
    chk({7'h00, drive_out[0].double_limit}, 8'h00);
    wr(SUPPLY_A_CONFIG_ADDR, 8'h03);
    wait_gate(0, 1'b1, FL + 10, n);
    @(posedge clk_in);
    short[0] <= 1'b1;
    repeat (1400 * T) @(posedge clk_in);
    #1 chk({6'h00, drive_out[0].gate_drive, drive_out[0].sense_enable}, 8'h02);
    off(0);
    for (int i = 0; i < 10; i++) begin
      set_volts(volt_t[i]);
      fault(0, cfg_t[i], n);
      chk_rng(n, exp_t[i] * T, exp_t[i] * T + T + 8);
      off(0);
    end
    set_volts(6'h18);
    fault(1, 8'h00, n);
    fault(0, 8'h40, n);
    wait_gate(0, 1'b1, RETRY_1_TICKS * T + 20, n);
    chk_rng(n, (RETRY_1_TICKS - 1) * T, RETRY_1_TICKS * T + T + 8);
    chk({7'h00, drive_out[1].gate_drive}, 8'h00);
    off(0);
    off(1);
    fault(0, 8'hc0, n);
    fault(1, 8'h80, n);
    repeat (RETRY_1_TICKS * T + 100) @(posedge clk_in);
    #1 chk({6'h00, drive_out[0].gate_drive, drive_out[1].gate_drive}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
